// [hw/ida_pkg.sv]
package ida_pkg;

  // Register indices on the register port.
  localparam logic [3:0] REG_P1_LOW = 4'h0;
  localparam logic [3:0] REG_P1_HIGH = 4'h1;
  localparam logic [3:0] REG_BANK = 4'h2;
  localparam logic [3:0] REG_P2_LOW = 4'h3;
  localparam logic [3:0] REG_P2_HIGH = 4'h4;
  localparam logic [3:0] REG_WORK = 4'h5;
  // Each operand window holds five indices starting at its base.
  localparam logic [3:0] OPR_BASE_P1 = 4'h6;
  localparam logic [3:0] OPR_BASE_P2 = 4'hb;

  // Operand kinds, as an offset from the pointer's operand base.
  localparam logic [2:0] OPK_PLAIN = 3'h0;
  localparam logic [2:0] OPK_POSTINC = 3'h1;
  localparam logic [2:0] OPK_POSTDEC = 3'h2;
  localparam logic [2:0] OPK_PREINC = 3'h3;
  localparam logic [2:0] OPK_INDEXED = 3'h4;

  localparam int HIGH_BITS = 4;
  localparam int BANK_BITS = 4;
  localparam int ADDR_BITS = 12;
  localparam logic [3:0] HIGH_RESET = 4'h0;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [7:0] UNIMPL_VALUE = 8'h00;

endpackage

// [hw/ida_unit.sv]
`timescale 1ns/1ps
// Functional notes
// - Plain operand uses pointer, pointer unchanged.
// - Post-increment: use pointer, then add one.
// - Post-decrement: use pointer, then subtract one.
// - Pre-increment: add one, then use pointer.
// - Indexed: address pointer plus working register.
// - High part four bits, cleared by reset.
// - Low byte not reset, contents unknown.
// - Unimplemented registers and bits read zero.
module ida_unit #(
  parameter bit HAS_POINTER2 = 1'b1
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port.
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Direct access address offset from the core.
  input wire logic [7:0] direct_addr_i,
  input wire logic direct_req_i,
  // Data memory side.
  output logic [11:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_wr_o,
  output logic mem_rd_o,
  input wire logic [7:0] mem_rdata_i
);

  logic [7:0] p_low_q [2];
  logic [3:0] p_high_q [2];
  logic [3:0] bank_q;
  logic [7:0] work_q;
  logic [7:0] rdata_q;
  logic [11:0] addr_q;
  logic [7:0] wdata_q;
  logic wr_q;
  logic rd_q;
  logic mem_pending_q;

  logic opr_hit;
  logic opr_sel;
  logic [2:0] opr_kind;
  logic [11:0] ptr_cur;
  logic [11:0] ptr_inc;
  logic [11:0] ptr_dec;
  logic [11:0] ptr_new;
  logic [11:0] opr_addr;
  logic ptr_write;

  // Decode an operand access and its pointer.
  always_comb begin
    opr_hit = 1'b0;
    opr_sel = 1'b0;
    opr_kind = ida_pkg::OPK_PLAIN;
    if ((reg_addr_i >= ida_pkg::OPR_BASE_P1) &&
        (reg_addr_i < ida_pkg::OPR_BASE_P1 + 4'h5)) begin
      opr_hit = 1'b1;
      opr_kind = 3'(reg_addr_i - ida_pkg::OPR_BASE_P1);
    end else if ((reg_addr_i >= ida_pkg::OPR_BASE_P2) &&
                 HAS_POINTER2) begin
      opr_hit = (reg_addr_i - ida_pkg::OPR_BASE_P2) < 4'h5;
      opr_sel = 1'b1;
      opr_kind = 3'(reg_addr_i - ida_pkg::OPR_BASE_P2);
    end
  end

  // Twelve-bit arithmetic lets carries run into the high part.
  always_comb begin
    ptr_cur = {p_high_q[opr_sel], p_low_q[opr_sel]};
    ptr_inc = ptr_cur + 12'h001;
    ptr_dec = ptr_cur - 12'h001;
    ptr_new = ptr_cur;
    opr_addr = ptr_cur;
    ptr_write = 1'b0;
    case (opr_kind)
      ida_pkg::OPK_POSTINC: begin
        ptr_new = ptr_inc;
        ptr_write = 1'b1;
      end
      ida_pkg::OPK_POSTDEC: begin
        ptr_new = ptr_dec;
        ptr_write = 1'b1;
      end
      ida_pkg::OPK_PREINC: begin
        ptr_new = ptr_inc;
        opr_addr = ptr_inc;
        ptr_write = 1'b1;
      end
      ida_pkg::OPK_INDEXED: begin
        opr_addr = ptr_cur + {4'h0, work_q};
      end
      default: begin
        opr_addr = ptr_cur;
      end
    endcase
  end

  logic opr_access;
  assign opr_access = opr_hit && (reg_wr_i || reg_rd_i);

  // Pointer storage; the low byte deliberately has no reset.
  for (genvar i = 0; i < 2; i++) begin : g_ptr
    always_ff @(posedge clk_i) begin
      if (opr_access && ptr_write && (opr_sel == 1'(i))) begin
        p_low_q[i] <= ptr_new[7:0];
      end else if (reg_wr_i && (reg_addr_i == (i == 0 ?
                   ida_pkg::REG_P1_LOW : ida_pkg::REG_P2_LOW))) begin
        p_low_q[i] <= reg_wdata_i;
      end
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        p_high_q[i] <= ida_pkg::HIGH_RESET;
      end else if (opr_access && ptr_write && (opr_sel == 1'(i))) begin
        p_high_q[i] <= ptr_new[11:8];
      end else if (reg_wr_i && (reg_addr_i == (i == 0 ?
                   ida_pkg::REG_P1_HIGH : ida_pkg::REG_P2_HIGH))) begin
        p_high_q[i] <= reg_wdata_i[3:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bank_q <= ida_pkg::BANK_RESET;
    end else if (reg_wr_i && reg_addr_i == ida_pkg::REG_BANK) begin
      bank_q <= reg_wdata_i[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      work_q <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == ida_pkg::REG_WORK) begin
      work_q <= reg_wdata_i;
    end
  end

  // Memory request; operand accesses win over a direct request.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_q <= 12'h000;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else if (opr_access) begin
      addr_q <= opr_addr;
      wdata_q <= reg_wdata_i;
      wr_q <= reg_wr_i;
      rd_q <= reg_rd_i;
    end else if (direct_req_i) begin
      addr_q <= {bank_q, direct_addr_i};
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b1;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
  end

  // An operand read returns memory data one cycle later, so the memory
  // must answer combinationally in the request cycle's following edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_pending_q <= 1'b0;
    end else begin
      mem_pending_q <= opr_hit && reg_rd_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= ida_pkg::UNIMPL_VALUE;
    end else if (reg_rd_i) begin
      if (reg_addr_i == ida_pkg::REG_P1_LOW) begin
        rdata_q <= p_low_q[0];
      end else if (reg_addr_i == ida_pkg::REG_P1_HIGH) begin
        rdata_q <= {4'h0, p_high_q[0]};
      end else if (reg_addr_i == ida_pkg::REG_BANK) begin
        rdata_q <= {4'h0, bank_q};
      end else if (reg_addr_i == ida_pkg::REG_P2_LOW && HAS_POINTER2) begin
        rdata_q <= p_low_q[1];
      end else if (reg_addr_i == ida_pkg::REG_P2_HIGH && HAS_POINTER2) begin
        rdata_q <= {4'h0, p_high_q[1]};
      end else if (reg_addr_i == ida_pkg::REG_WORK) begin
        rdata_q <= work_q;
      end else begin
        rdata_q <= ida_pkg::UNIMPL_VALUE;
      end
    end
  end

  assign mem_addr_o = addr_q;
  assign mem_wdata_o = wdata_q;
  assign mem_wr_o = wr_q;
  assign mem_rd_o = rd_q;
  assign reg_rdata_o = mem_pending_q ? mem_rdata_i : rdata_q;

  // Reads and writes both move the pointer, so the request sequences
  // accept either strobe.
  sequence postinc_req_s;
    (reg_wr_i || reg_rd_i) && reg_addr_i == ida_pkg::OPR_BASE_P1 + 4'h1;
  endsequence

  sequence postdec_req_s;
    (reg_wr_i || reg_rd_i) && reg_addr_i == ida_pkg::OPR_BASE_P1 + 4'h2;
  endsequence

  post_inc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    postinc_req_s |=> mem_addr_o == $past({p_high_q[0], p_low_q[0]})
      && {p_high_q[0], p_low_q[0]} == mem_addr_o + 12'h001)
    else $error("post increment wrong");

  post_dec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    postdec_req_s |=>
      {p_high_q[0], p_low_q[0]} == mem_addr_o - 12'h001)
    else $error("post decrement wrong");

  pre_inc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (reg_wr_i || reg_rd_i) && reg_addr_i == ida_pkg::OPR_BASE_P1 + 4'h3 |=>
      {p_high_q[0], p_low_q[0]} == mem_addr_o)
    else $error("pre increment wrong");

  plain_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (reg_wr_i || reg_rd_i) && reg_addr_i == ida_pkg::OPR_BASE_P1 |=>
      $stable({p_high_q[0], p_low_q[0]}) &&
      mem_addr_o == {p_high_q[0], p_low_q[0]})
    else $error("plain operand moved pointer");

  indexed_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (reg_wr_i || reg_rd_i) && reg_addr_i == ida_pkg::OPR_BASE_P1 + 4'h4 |=>
      mem_addr_o == {p_high_q[0], p_low_q[0]} + {4'h0, work_q})
    else $error("indexed address wrong");

  high_reset_a: assert property (@(posedge clk_i)
    rst_i |=> p_high_q[0] == 4'h0 && p_high_q[1] == 4'h0)
    else $error("high part not cleared");

  bank_reset_a: assert property (@(posedge clk_i)
    rst_i |=> bank_q == 4'h0)
    else $error("bank select not cleared");

  unimpl_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == 4'hf && !opr_hit |=>
      reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");

  direct_bank_a: assert property (@(posedge clk_i) disable iff (rst_i)
    direct_req_i && !opr_access |=>
      mem_addr_o[11:8] == $past(bank_q))
    else $error("direct bank wrong");

  carry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (postinc_req_s and (p_low_q[0] == 8'hff)) |=>
      p_low_q[0] == 8'h00 && p_high_q[0] == $past(p_high_q[0]) + 4'h1)
    else $error("carry not propagated");

  borrow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (postdec_req_s and (p_low_q[0] == 8'h00)) |=>
      p_low_q[0] == 8'hff && p_high_q[0] == $past(p_high_q[0]) - 4'h1)
    else $error("borrow not propagated");

  index_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (reg_wr_i || reg_rd_i) && reg_addr_i == ida_pkg::OPR_BASE_P1 + 4'h4 |=>
      $stable({p_high_q[0], p_low_q[0]}))
    else $error("indexed operand moved pointer");

  // Pointer 2 checks mirror the pointer 1 set except borrow_a and index_keep_a; the small variant never
  // arms them because p2_req_s requires HAS_POINTER2.
  sequence p2_req_s;
    HAS_POINTER2 && (reg_wr_i || reg_rd_i);
  endsequence

  p2_post_inc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    p2_req_s ##0 reg_addr_i == ida_pkg::OPR_BASE_P2 + 4'h1 |=>
      mem_addr_o == $past({p_high_q[1], p_low_q[1]}) &&
      {p_high_q[1], p_low_q[1]} == mem_addr_o + 12'h001)
    else $error("pointer 2 post increment wrong");

  p2_post_dec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    p2_req_s ##0 reg_addr_i == ida_pkg::OPR_BASE_P2 + 4'h2 |=>
      {p_high_q[1], p_low_q[1]} == mem_addr_o - 12'h001)
    else $error("pointer 2 post decrement wrong");

  p2_pre_inc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    p2_req_s ##0 reg_addr_i == ida_pkg::OPR_BASE_P2 + 4'h3 |=>
      {p_high_q[1], p_low_q[1]} == mem_addr_o)
    else $error("pointer 2 pre increment wrong");

  p2_plain_a: assert property (@(posedge clk_i) disable iff (rst_i)
    p2_req_s ##0 reg_addr_i == ida_pkg::OPR_BASE_P2 |=>
      $stable({p_high_q[1], p_low_q[1]}) &&
      mem_addr_o == {p_high_q[1], p_low_q[1]})
    else $error("pointer 2 plain operand moved pointer");

  p2_index_a: assert property (@(posedge clk_i) disable iff (rst_i)
    p2_req_s ##0 reg_addr_i == ida_pkg::OPR_BASE_P2 + 4'h4 |=>
      mem_addr_o == {p_high_q[1], p_low_q[1]} + {4'h0, work_q})
    else $error("pointer 2 indexed address wrong");

  p2_carry_a: assert property (@(posedge clk_i) disable iff (rst_i)
    p2_req_s ##0 reg_addr_i == ida_pkg::OPR_BASE_P2 + 4'h1 ##0
      p_low_q[1] == 8'hff |=>
      p_low_q[1] == 8'h00 && p_high_q[1] == $past(p_high_q[1]) + 4'h1)
    else $error("pointer 2 carry not propagated");

  wdata_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    opr_access && reg_wr_i |=>
      mem_wr_o && mem_wdata_o == $past(reg_wdata_i))
    else $error("operand write data lost");

  small_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !HAS_POINTER2 && reg_rd_i && reg_addr_i == ida_pkg::REG_P2_LOW |=>
      reg_rdata_o == 8'h00)
    else $error("missing pointer not zero");

  bank_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == ida_pkg::REG_BANK |=>
      reg_rdata_o[7:4] == 4'h0)
    else $error("bank select upper bits not zero");

  high_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == ida_pkg::REG_P1_HIGH |=>
      reg_rdata_o[7:4] == 4'h0)
    else $error("high part upper bits not zero");

  direct_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    direct_req_i && !opr_access |=> mem_rd_o && !mem_wr_o)
    else $error("direct request not a read");

endmodule

// [verification/ida_unit_bench.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (e)); end end
module ida_unit_bench;
  typedef struct packed {
    logic [2:0] kind;
    logic [11:0] ptr;
    logic [11:0] ea;
    logic [11:0] ep;
  } ida_row_s;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] direct_addr_i = 8'h00;
  logic direct_req_i = 1'b0;
  logic [7:0] reg_rdata_o, small_rdata;
  logic [11:0] mem_addr_o;
  logic [7:0] mem_wdata_o, mem_rdata_i;
  logic mem_wr_o, mem_rd_o;
  int fail_count = 0;
  int num_checks = 0;
  // Boundary pointers make the carry and borrow cross into the high part.
  ida_row_s rows[5] = '{
    '{ida_pkg::OPK_PLAIN, 12'h3a5, 12'h3a5, 12'h3a5},
    '{ida_pkg::OPK_POSTINC, 12'h0ff, 12'h0ff, 12'h100},
    '{ida_pkg::OPK_POSTDEC, 12'h100, 12'h100, 12'h0ff},
    '{ida_pkg::OPK_PREINC, 12'hfff, 12'h000, 12'h000},
    '{ida_pkg::OPK_INDEXED, 12'h0f0, 12'h110, 12'h0f0}};
  always #50 clk_i = ~clk_i;
  // Memory answers combinationally with a value derived from the address.
  assign mem_rdata_i = mem_rd_o ? (mem_addr_o[7:0] ^ 8'h5a) : 8'h00;
  ida_unit ida_unit_inst (.clk_i(clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .direct_addr_i(direct_addr_i), .direct_req_i(direct_req_i),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_wr_o(mem_wr_o), .mem_rd_o(mem_rd_o), .mem_rdata_i(mem_rdata_i));
  // Smaller variant without the second pointer shares the register port.
  ida_unit #(.HAS_POINTER2(1'b0)) ida_unit_inst2 (.clk_i(clk_i),
    .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(small_rdata),
    .direct_addr_i(direct_addr_i), .direct_req_i(1'b0), .mem_addr_o(),
    .mem_wdata_o(), .mem_wr_o(), .mem_rd_o(), .mem_rdata_i(8'h00));

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Called just after a rising edge; returns just after the taking edge.
  task automatic acc(input logic [3:0] a, input logic [7:0] d,
                     input logic w);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= w;
    reg_rd_i <= ~w;
    @(posedge clk_i);
  endtask

  // Strobes stay up between back-to-back calls; this drops them.
  task automatic idle();
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    acc(a, 8'h00, 1'b0);
    idle();
    @(negedge clk_i);
    `CHK(reg_rdata_o, e)
    @(posedge clk_i);
  endtask

  initial begin
    logic [3:0] base, lo, hi;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(ida_pkg::REG_P1_HIGH, 8'h00);
    rdchk(ida_pkg::REG_P2_HIGH, 8'h00);
    rdchk(ida_pkg::REG_BANK, 8'h00);
    for (int i = 0; i < 5; i++) begin
      for (int p = 0; p < 2; p++) begin
        base = (p == 1) ? ida_pkg::OPR_BASE_P2 : ida_pkg::OPR_BASE_P1;
        lo = (p == 1) ? ida_pkg::REG_P2_LOW : ida_pkg::REG_P1_LOW;
        hi = (p == 1) ? ida_pkg::REG_P2_HIGH : ida_pkg::REG_P1_HIGH;
        acc(ida_pkg::REG_WORK, 8'h20, 1'b1);
        acc(lo, rows[i].ptr[7:0], 1'b1);
        acc(hi, {4'h0, rows[i].ptr[11:8]}, 1'b1);
        acc(base + {1'b0, rows[i].kind}, 8'hc3, p[0]);
        idle();
        @(negedge clk_i);
        `CHK(mem_addr_o, rows[i].ea)
        `CHK((p == 1) ? mem_wr_o : mem_rd_o, 1'b1)
        if (p == 1) begin
          `CHK(mem_wdata_o, 8'hc3)
        end else begin
          `CHK(reg_rdata_o, rows[i].ea[7:0] ^ 8'h5a)
        end
        @(posedge clk_i);
        rdchk(lo, rows[i].ep[7:0]);
        rdchk(hi, {4'h0, rows[i].ep[11:8]});
      end
    end
    // Back-to-back post-increments with the strobe held for two cycles.
    acc(ida_pkg::REG_P1_LOW, 8'h40, 1'b1);
    reg_addr_i <= ida_pkg::OPR_BASE_P1 + 4'h1;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK(mem_addr_o, 12'h040)
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(negedge clk_i);
    `CHK(mem_addr_o, 12'h041)
    @(posedge clk_i);
    rdchk(ida_pkg::REG_P1_LOW, 8'h42);
    acc(ida_pkg::REG_P1_HIGH, 8'hff, 1'b1);
    rdchk(ida_pkg::REG_P1_HIGH, 8'h0f);
    acc(ida_pkg::REG_P2_HIGH, 8'h05, 1'b1);
    acc(ida_pkg::REG_P2_HIGH, 8'h00, 1'b0);
    idle();
    @(negedge clk_i);
    `CHK(reg_rdata_o, 8'h05)
    `CHK(small_rdata, 8'h00)
    @(posedge clk_i);
    acc(4'hf, 8'h00, 1'b0);
    idle();
    @(negedge clk_i);
    `CHK(small_rdata, 8'h00)
    @(posedge clk_i);
    acc(ida_pkg::REG_BANK, 8'hff, 1'b1);
    rdchk(ida_pkg::REG_BANK, 8'h0f);
    direct_addr_i <= 8'h34;
    direct_req_i <= 1'b1;
    @(posedge clk_i);
    direct_req_i <= 1'b0;
    @(negedge clk_i);
    `CHK(mem_addr_o, 12'hf34)
    `CHK(mem_rd_o, 1'b1)
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(ida_pkg::REG_P1_HIGH, 8'h00);
    rdchk(ida_pkg::REG_BANK, 8'h00);
    close_out();
  end

  // The sequence needs about 130 cycles; this leaves a wide margin.
  initial begin
    #500000;
    fail_count++;
    close_out();
  end
endmodule
